// >>> core/rsc_pkg.sv
// Constants shared by the reset source controller
package rsc_pkg;
  // Core clock period
  localparam int CLK_PERIOD_NS = 8;
  // Least time the low-supply indication must persist
  localparam int LOW_SUP_FILTER_NS = 120;
  localparam logic [4:0] LS_FILT_CYC = 5'((LOW_SUP_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // Length of the chip reset pulse after a full reset event
  localparam int RST_HOLD_NS = 64;
  localparam logic [3:0] RST_HOLD_CYC = 4'((RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Register byte addresses
  localparam logic [11:0] OFS_CAUSE_FLAGS = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_FLASH_CTRL1 = 12'h008;
  localparam logic [11:0] OFS_MODE_STAT = 12'h00c;

  // Field positions
  localparam int BIT_LOW_SUPPLY_RESET_FLAG = 2;
  localparam int BIT_WRF = 0;
  localparam int BIT_TO = 5;
  localparam int BIT_PDF = 4;
  localparam int BIT_RUN = 0;
  localparam int BIT_MON = 1;
  localparam int BIT_HOLD = 2;

  // Implemented bits of the cause flag register
  localparam logic [7:0] CAUSE_MASK = 8'h05;
  // Value written to flash control 1 that resets the chip
  localparam logic [7:0] FLASH_RESET_KEY = 8'h55;

  // Reset values
  localparam logic [7:0] PORT_INIT_VAL = 8'hff;
  localparam logic [7:0] FLASH_CTRL1_RST = 8'h00;
  localparam logic [7:0] CAUSE_FLAGS_RST = 8'h00;

  // Sequencer states, one-hot
  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_HOLD = 2'b10
  } rsc_state_e;
endpackage : rsc_pkg

// >>> core/rsc_reset_ctrl.sv
// Reset source controller: combines reset sources, records causes, APB registers
//
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/1ps
module rsc_reset_ctrl
  import rsc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Reset sources and core events
  input wire logic low_supply_raw,
  input wire logic run_mode,
  input wire logic wdog_timeout,
  input wire logic wdog_ctrl_bad_write,
  input wire logic halt_exec,
  input wire logic clr_wdog,
  // Reset effects toward the core
  output logic chip_reset,
  output logic pc_clear,
  output logic sp_to_top,
  output logic port_init,
  output logic [7:0] port_init_value,
  output logic intr_disable,
  output logic timers_off,
  output logic wdog_clear,
  output logic low_supply_mon_en,
  output logic timeout_flag,
  output logic powerdown_flag
);

  rsc_state_e state;
  logic [3:0] hold_cnt;
  logic ls_meta;
  logic ls_sync;
  logic [4:0] ls_cnt;
  logic lsr_evt;
  logic fc1_trig;
  logic full_evt;
  logic sleep_evt;
  logic apb_wr;
  logic apb_setup_rd;
  logic [7:0] cause_flags;
  logic [7:0] flash_ctrl1;
  logic pc_sp_pulse;

  // True when the address hits an implemented register
  function automatic logic addr_mapped(input logic [11:0] a);
    addr_mapped = (a == OFS_CAUSE_FLAGS) || (a == OFS_STATUS) ||
                  (a == OFS_FLASH_CTRL1) || (a == OFS_MODE_STAT);
  endfunction : addr_mapped

  // Status word: timeout and powerdown flags at their fixed bit places
  function automatic logic [31:0] status_word(input logic to_f, input logic pd_f);
    status_word = (32'(to_f) << BIT_TO) | (32'(pd_f) << BIT_PDF);
  endfunction : status_word

  // Mode word: run mode, monitor enable and reset hold, widened before shifting
  function automatic logic [31:0] mode_word(input logic run_f, input logic mon_f, input logic hold_f);
    mode_word = (32'(run_f) << BIT_RUN) | (32'(mon_f) << BIT_MON) | (32'(hold_f) << BIT_HOLD);
  endfunction : mode_word

  // Zero wait states: every access phase completes at once
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_mapped(paddr);
  assign apb_wr = psel && penable && pwrite;
  assign apb_setup_rd = psel && !penable && !pwrite;

  // Two-stage synchroniser for the analog low-supply comparator
  always_ff @(posedge clk) begin
    if (rst) begin
      ls_meta <= 1'b0;
      ls_sync <= 1'b0;
    end else begin
      ls_meta <= low_supply_raw;
      ls_sync <= ls_meta;
    end
  end

  // Monitor follows the core power mode; off in sleep and idle
  always_ff @(posedge clk) begin
    if (rst) begin
      low_supply_mon_en <= 1'b1;
    end else begin
      low_supply_mon_en <= run_mode;
    end
  end

  // Filter: count cycles of low supply, saturate so one dip fires once
  always_ff @(posedge clk) begin
    if (rst) begin
      ls_cnt <= 5'h00;
    end else if (!ls_sync || !low_supply_mon_en) begin
      ls_cnt <= 5'h00;
    end else if (ls_cnt <= LS_FILT_CYC) begin
      ls_cnt <= ls_cnt + 5'h01;
    end
  end

  // Fires once the dip has lasted longer than the filter time
  assign lsr_evt = ls_sync && low_supply_mon_en && (ls_cnt == LS_FILT_CYC);
  assign fc1_trig = apb_wr && (paddr == OFS_FLASH_CTRL1) && (pwdata[7:0] == FLASH_RESET_KEY);
  // All sources that reinitialise the whole chip
  assign full_evt = lsr_evt || fc1_trig || (wdog_timeout && run_mode) || wdog_ctrl_bad_write;
  // Sleep wake-up timeout clears only PC and SP and sets the powerdown flag
  assign sleep_evt = wdog_timeout && !run_mode;

  // Reset sequencer: assert on the edge after any event, release after hold time
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= ST_HOLD;
      hold_cnt <= RST_HOLD_CYC;
    end else begin
      case (state)
        ST_RUN: begin
          if (full_evt) begin
            state <= ST_HOLD;
            hold_cnt <= RST_HOLD_CYC;
          end
        end
        ST_HOLD: begin
          // A fresh event restarts the hold so every source gets a full pulse
          if (full_evt) begin
            hold_cnt <= RST_HOLD_CYC;
          end else if (hold_cnt == 4'h1) begin
            state <= ST_RUN;
            hold_cnt <= 4'h0;
          end else begin
            hold_cnt <= hold_cnt - 4'h1;
          end
        end
        default: begin
          state <= ST_HOLD;
          hold_cnt <= RST_HOLD_CYC;
        end
      endcase
    end
  end

  // One-cycle PC/SP clear for a timeout in sleep or idle
  always_ff @(posedge clk) begin
    if (rst) begin
      pc_sp_pulse <= 1'b0;
    end else begin
      pc_sp_pulse <= sleep_evt;
    end
  end

  // Reset effects, all from state flops
  assign chip_reset = (state == ST_HOLD);
  assign pc_clear = chip_reset || pc_sp_pulse;
  // Top of stack is the zero position, so a sleep wake-up reuses this line
  assign sp_to_top = chip_reset || pc_sp_pulse;
  assign port_init = chip_reset;
  assign intr_disable = chip_reset;
  assign timers_off = chip_reset;
  assign wdog_clear = chip_reset;

  // Port load value is a constant held in a flop
  always_ff @(posedge clk) begin
    if (rst) begin
      port_init_value <= PORT_INIT_VAL;
    end else begin
      port_init_value <= PORT_INIT_VAL;
    end
  end

  // Cause flags: hardware set beats a simultaneous software clear
  always_ff @(posedge clk) begin
    if (rst) begin
      cause_flags <= CAUSE_FLAGS_RST;
    end else begin
      if (lsr_evt) begin
        cause_flags[BIT_LOW_SUPPLY_RESET_FLAG] <= 1'b1;
      end else if (apb_wr && (paddr == OFS_CAUSE_FLAGS) && !pwdata[BIT_LOW_SUPPLY_RESET_FLAG]) begin
        cause_flags[BIT_LOW_SUPPLY_RESET_FLAG] <= 1'b0;
      end
      if (wdog_ctrl_bad_write) begin
        cause_flags[BIT_WRF] <= 1'b1;
      end else if (apb_wr && (paddr == OFS_CAUSE_FLAGS) && !pwdata[BIT_WRF]) begin
        cause_flags[BIT_WRF] <= 1'b0;
      end
    end
  end

  // Timeout flag: set by any watchdog timeout, untouched by other resets
  always_ff @(posedge clk) begin
    if (rst) begin
      timeout_flag <= 1'b0;
    end else if (wdog_timeout) begin
      timeout_flag <= 1'b1;
    end
  end

  // Powerdown flag: halt or sleep timeout set it, clear-watchdog clears it
  always_ff @(posedge clk) begin
    if (rst) begin
      powerdown_flag <= 1'b0;
    end else if (halt_exec || sleep_evt) begin
      powerdown_flag <= 1'b1;
    end else if (clr_wdog) begin
      powerdown_flag <= 1'b0;
    end
  end

  // Flash control 1 returns to zero on every full reset
  always_ff @(posedge clk) begin
    if (rst || chip_reset) begin
      flash_ctrl1 <= FLASH_CTRL1_RST;
    end else if (apb_wr && (paddr == OFS_FLASH_CTRL1)) begin
      flash_ctrl1 <= pwdata[7:0];
    end
  end

  // Read data is captured in the setup phase so it stands through the access
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (apb_setup_rd) begin
      if (paddr == OFS_CAUSE_FLAGS) begin
        prdata <= {24'h00_0000, cause_flags & CAUSE_MASK};
      end else if (paddr == OFS_STATUS) begin
        prdata <= status_word(timeout_flag, powerdown_flag);
      end else if (paddr == OFS_FLASH_CTRL1) begin
        prdata <= {24'h00_0000, flash_ctrl1};
      end else if (paddr == OFS_MODE_STAT) begin
        prdata <= mode_word(run_mode, low_supply_mon_en, chip_reset);
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // Helper: independent run length of the synchronised low-supply level
  logic [7:0] chk_ls_len;
  always_ff @(posedge clk) begin
    if (rst || !ls_sync || !low_supply_mon_en) begin
      chk_ls_len <= 8'h00;
    end else if (chk_ls_len != 8'hff) begin
      chk_ls_len <= chk_ls_len + 8'h01;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_por_pc_clear: assert property ($fell(rst) |-> chip_reset && pc_clear)
    else $error("program counter not cleared after power-on");
  chk_por_port_ones: assert property ($fell(rst) |-> port_init && (port_init_value == 8'hff))
    else $error("ports not loaded with ones after power-on");
  chk_lsr_full_reset: assert property (lsr_evt |=> chip_reset ##1 chip_reset)
    else $error("low-supply event gave no full reset");
  chk_monitor_gating: assert property (!run_mode |=> !low_supply_mon_en ##0 !lsr_evt)
    else $error("low-supply monitor active outside run mode");
  chk_filter_minimum: assert property (lsr_evt |-> chk_ls_len >= 8'(LS_FILT_CYC))
    else $error("low-supply reset before filter time");
  chk_low_supply_reset_flag_set: assert property (lsr_evt |=> cause_flags[2])
    else $error("low-supply flag not set");
  chk_low_supply_reset_flag_sticky: assert property (cause_flags[2] && !(apb_wr && paddr == OFS_CAUSE_FLAGS && !pwdata[2])
    |=> cause_flags[2])
    else $error("low-supply flag cleared without software");
  chk_unimpl_bits_zero: assert property (apb_setup_rd && paddr == OFS_CAUSE_FLAGS
    |=> prdata[7:3] == 5'h00 && !prdata[1])
    else $error("unimplemented flag bits read non-zero");
  chk_flash_key_reset: assert property (apb_wr && paddr == OFS_FLASH_CTRL1 && pwdata[7:0] == 8'h55
    |=> chip_reset)
    else $error("flash key write gave no reset");
  chk_run_timeout: assert property (wdog_timeout && run_mode |=> chip_reset && timeout_flag)
    else $error("run-mode timeout mishandled");
  chk_sleep_timeout: assert property (sleep_evt && !full_evt && state == ST_RUN
    |=> pc_clear && sp_to_top && timeout_flag && powerdown_flag && !chip_reset ##1 !pc_clear)
    else $error("sleep timeout mishandled");
  chk_por_flags_clear: assert property ($fell(rst) |-> !timeout_flag && !powerdown_flag)
    else $error("status flags not cleared on power-on");
  chk_lsr_keeps_flags: assert property (lsr_evt && !wdog_timeout && !halt_exec && !clr_wdog
    |=> $stable(timeout_flag) && $stable(powerdown_flag))
    else $error("low-supply reset altered status flags");
  chk_por_core_state: assert property ($fell(rst) |-> intr_disable && wdog_clear && timers_off && sp_to_top)
    else $error("core state not forced on power-on");
  chk_wrf_set: assert property (wdog_ctrl_bad_write |=> cause_flags[0] && chip_reset)
    else $error("watchdog control reset flag not set");
  chk_halt_pdf: assert property (halt_exec |=> powerdown_flag)
    else $error("halt did not set powerdown flag");
  chk_sync_release: assert property ($fell(chip_reset) |-> $past(hold_cnt) == 4'h1 && !$past(full_evt))
    else $error("chip reset released out of sequence");

  // Retention and sequencing: flags only move on their own events
  chk_wrf_sticky: assert property (cause_flags[0] && !(apb_wr && paddr == OFS_CAUSE_FLAGS && !pwdata[0])
    |=> cause_flags[0])
    else $error("watchdog control flag cleared without software");
  chk_pdf_clear: assert property (clr_wdog && !halt_exec && !sleep_evt |=> !powerdown_flag)
    else $error("clear-watchdog did not clear powerdown flag");
  chk_lsr_once: assert property (lsr_evt |=> !lsr_evt)
    else $error("one low-supply dip fired twice");
  chk_mon_run: assert property (run_mode |=> low_supply_mon_en)
    else $error("low-supply monitor off in run mode");
  chk_hold_length: assert property (full_evt |=> chip_reset [*8])
    else $error("chip reset pulse too short");
  chk_flash_cleared: assert property (chip_reset |=> flash_ctrl1 == FLASH_CTRL1_RST)
    else $error("flash control kept its value through reset");
  chk_cause_unused_zero: assert property ((cause_flags & ~CAUSE_MASK) == 8'h00)
    else $error("unimplemented cause bits became set");
  chk_timeout_sticky: assert property (timeout_flag |=> timeout_flag)
    else $error("timeout flag lost without power-on");
  chk_key_only: assert property (apb_wr && paddr == OFS_FLASH_CTRL1 && pwdata[7:0] != FLASH_RESET_KEY
    && state == ST_RUN && !full_evt |=> !chip_reset)
    else $error("flash write without key reset the chip");

  cov_lsr_reset: cover property (lsr_evt ##1 chip_reset);
  cov_ctrl_reset: cover property (wdog_ctrl_bad_write ##1 chip_reset);
  cov_sleep_wake: cover property (sleep_evt ##1 pc_clear);
  cov_flash_reset: cover property (fc1_trig ##1 chip_reset);
  cov_flag_clear: cover property (cause_flags[2] ##1 !cause_flags[2]);

endmodule : rsc_reset_ctrl

// >>> verif/rsc_reset_ctrl_bench.sv
// Self-checking bench for the reset source controller
`timescale 1ns/1ps
module rsc_reset_ctrl_bench import rsc_pkg::*;;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic low_supply_raw = 1'b0;
  logic run_mode = 1'b1;
  logic wdog_timeout = 1'b0;
  logic wdog_ctrl_bad_write = 1'b0;
  logic halt_exec = 1'b0;
  logic clr_wdog = 1'b0;
  logic chip_reset, pc_clear, sp_to_top, port_init, intr_disable, timers_off, wdog_clear;
  logic low_supply_mon_en, timeout_flag, powerdown_flag;
  logic [7:0] port_init_value;
  logic [31:0] rd;
  logic er;
  logic saw;
  int n;
  int cycles = 0;
  int bad_count = 0;
  int tests_run = 0;

  always #4 clk = ~clk;

  rsc_reset_ctrl rsc_reset_ctrl_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .low_supply_raw(low_supply_raw), .run_mode(run_mode), .wdog_timeout(wdog_timeout),
    .wdog_ctrl_bad_write(wdog_ctrl_bad_write), .halt_exec(halt_exec), .clr_wdog(clr_wdog),
    .chip_reset(chip_reset), .pc_clear(pc_clear), .sp_to_top(sp_to_top), .port_init(port_init),
    .port_init_value(port_init_value), .intr_disable(intr_disable), .timers_off(timers_off),
    .wdog_clear(wdog_clear), .low_supply_mon_en(low_supply_mon_en), .timeout_flag(timeout_flag),
    .powerdown_flag(powerdown_flag));

  // Verdict and end of run, the only exit
  task wrap_up;
    if (bad_count == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up

  // Hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      wrap_up();
    end
  end

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One APB transfer; the request stands until pready is seen high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(what, exp, rd);
  endtask : rdchk

  // One-cycle event pulse; returns just after the edge that takes it
  task pulse(input int k);
    @(posedge clk);
    case (k)
      0: wdog_timeout <= 1'b1;
      1: wdog_ctrl_bad_write <= 1'b1;
      2: halt_exec <= 1'b1;
      default: clr_wdog <= 1'b1;
    endcase
    @(posedge clk);
    {wdog_timeout, wdog_ctrl_bad_write, halt_exec, clr_wdog} <= 4'h0;
    #1;
  endtask : pulse

  // Counts the cycles that chip_reset stays high from now on
  task hold(output int c);
    c = 0;
    while (chip_reset === 1'b1 && c < 50) begin
      @(posedge clk);
      #1;
      c++;
    end
  endtask : hold

  // Low-supply dip of len cycles; reports whether a chip reset was seen
  task dip(input int len, output logic s);
    s = 1'b0;
    @(posedge clk);
    low_supply_raw <= 1'b1;
    repeat (len) begin
      @(posedge clk);
      if (chip_reset === 1'b1) s = 1'b1;
    end
    low_supply_raw <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask : dip

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("reset effects", 32'h7f, 32'({chip_reset, pc_clear, sp_to_top, port_init, intr_disable,
      timers_off, wdog_clear}));
    chk("port init value", 32'(PORT_INIT_VAL), 32'(port_init_value));
    hold(n);
    chk("power-on hold", 32'(RST_HOLD_CYC), n);
    chk("effects released", 32'h0, 32'({chip_reset, pc_clear, sp_to_top, port_init}));
    rdchk("cause after power-on", OFS_CAUSE_FLAGS, 32'h0);
    rdchk("status after power-on", OFS_STATUS, 32'h0);
    rdchk("mode in run", OFS_MODE_STAT, 32'h3);
    rdchk("unmapped read", 12'h010, 32'h0);
    chk("unmapped error", 32'h1, 32'(er));
    // Halt then a long dip: powerdown must survive the low-supply reset
    pulse(2);
    rdchk("status after halt", OFS_STATUS, 32'h10);
    dip(10, saw);
    chk("short dip ignored", 32'h0, 32'(saw));
    dip(30, saw);
    chk("long dip resets", 32'h1, 32'(saw));
    rdchk("cause after dip", OFS_CAUSE_FLAGS, 32'h4);
    rdchk("status kept by dip", OFS_STATUS, 32'h10);
    pulse(3);
    rdchk("status after clear", OFS_STATUS, 32'h0);
    // Writing ones must not clear, writing zero clears
    apb(1'b1, OFS_CAUSE_FLAGS, 32'hff);
    rdchk("cause ones kept", OFS_CAUSE_FLAGS, 32'h4);
    apb(1'b1, OFS_CAUSE_FLAGS, 32'h0);
    rdchk("cause cleared", OFS_CAUSE_FLAGS, 32'h0);
    // Run-mode watchdog overflow
    pulse(0);
    chk("run timeout reset", 32'h3, 32'({chip_reset, timeout_flag}));
    hold(n);
    chk("reset hold", 32'(RST_HOLD_CYC), n);
    rdchk("status run timeout", OFS_STATUS, 32'h20);
    // Watchdog control software reset
    pulse(1);
    chk("ctrl reset", 32'h1, 32'(chip_reset));
    hold(n);
    rdchk("cause ctrl flag", OFS_CAUSE_FLAGS, 32'h1);
    apb(1'b1, OFS_CAUSE_FLAGS, 32'h0);
    rdchk("ctrl flag cleared", OFS_CAUSE_FLAGS, 32'h0);
    // Flash control: only the key value resets
    apb(1'b1, OFS_FLASH_CTRL1, 32'h12);
    #1;
    chk("no reset on other value", 32'h0, 32'(chip_reset));
    rdchk("flash readback", OFS_FLASH_CTRL1, 32'h12);
    apb(1'b1, OFS_FLASH_CTRL1, 32'(FLASH_RESET_KEY));
    #1;
    chk("key resets", 32'h1, 32'(chip_reset));
    hold(n);
    rdchk("flash cleared", OFS_FLASH_CTRL1, 32'(FLASH_CTRL1_RST));
    // Sleep: monitor off, overflow clears only PC and SP
    @(posedge clk);
    run_mode <= 1'b0;
    rdchk("mode in sleep", OFS_MODE_STAT, 32'h0);
    pulse(2);
    pulse(0);
    chk("sleep timeout", 32'h3, 32'({chip_reset, pc_clear, sp_to_top}));
    @(posedge clk);
    #1;
    chk("pc clear one cycle", 32'h0, 32'({pc_clear, sp_to_top}));
    rdchk("status sleep timeout", OFS_STATUS, 32'h30);
    dip(30, saw);
    chk("dip in sleep ignored", 32'h0, 32'(saw));
    rdchk("cause after sleep dip", OFS_CAUSE_FLAGS, 32'h0);
    // Second power-on reset in mid-run
    @(posedge clk);
    run_mode <= 1'b1;
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("second reset effects", 32'h7f, 32'({chip_reset, pc_clear, sp_to_top, port_init, intr_disable,
      timers_off, wdog_clear}));
    hold(n);
    chk("second reset hold", 32'(RST_HOLD_CYC), n);
    rdchk("status after second reset", OFS_STATUS, 32'h0);
    wrap_up();
  end
endmodule : rsc_reset_ctrl_bench
